// [fcs_consts.svh]
// Constants of the configuration sequencer
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH
`define FCS_CLK_NS 5
`define FCS_T_CF2CD_NS 500
`define FCS_CF2CD_CYC (`FCS_T_CF2CD_NS / `FCS_CLK_NS)
`define FCS_T_STATUS_MIN_US 45
`define FCS_STATUS_MIN_CYC ((`FCS_T_STATUS_MIN_US * 1000) / `FCS_CLK_NS)
`define FCS_T_CD2UM_MIN_US 300
`define FCS_CD2UM_CYC ((`FCS_T_CD2UM_MIN_US * 1000) / `FCS_CLK_NS)
`define FCS_T_POR_US 100
`define FCS_POR_CYC ((`FCS_T_POR_US * 1000) / `FCS_CLK_NS)
`define FCS_T_CFG_BYTE_CLOCK_MAX_NS 10
`define FCS_CD2CU_PERIODS 4
`define FCS_CD2CU_CYC \
  ((`FCS_CD2CU_PERIODS * `FCS_T_CFG_BYTE_CLOCK_MAX_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_INIT_CYCLES 3000
`define FCS_DONE_FALLS 2'h2
`define FCS_CNT_W 17
`define FCS_IR_W 4
`define FCS_IR_CAPTURE 4'h1
`define FCS_IR_BYPASS 4'hf
`define FCS_IR_PROGRAM 4'h2
`define FCS_SEL_ACTIVE_SERIAL 4'h2
`define FCS_FIFO_DEPTH 8
`define FCS_BYTE_W 8
`endif

// [fcs_pkg.sv]
// Types of the configuration sequencer
package fcs_pkg;
  typedef enum logic [2:0] {
    ST_POR = 3'h0, ST_RESET = 3'h1, ST_LOAD = 3'h2, ST_INITW = 3'h3,
    ST_INITD = 3'h4, ST_INITU = 3'h5, ST_USER = 3'h6, ST_JTAG = 3'h7
  } fcs_state_e;
  typedef enum logic [3:0] {
    TAP_TLR = 4'hf, TAP_RTI = 4'hc, TAP_SELDR = 4'h7, TAP_CAPDR = 4'h6,
    TAP_SHDR = 4'h2, TAP_EX1DR = 4'h1, TAP_PSDR = 4'h3, TAP_EX2DR = 4'h0,
    TAP_UPDR = 4'h5, TAP_SELIR = 4'h4, TAP_CAPIR = 4'he, TAP_SHIR = 4'ha,
    TAP_EX1IR = 4'h9, TAP_PSIR = 4'hb, TAP_EX2IR = 4'h8, TAP_UPIR = 4'hd
  } fcs_tap_e;
  typedef struct packed {
    logic req;        // Configuration request, active low
    logic cfg_byte_clock;       // Byte clock
    logic [7:0] data; // Byte data
    logic uclk;       // User init clock
    logic tck;
    logic tms;
    logic tdi;
    logic [3:0] sel;  // Scheme select straps
  } fcs_pins_s;
endpackage

// [fcs_top.sv]
// Configuration sequencer with byte FIFO and boundary-scan loader
`timescale 1ns/1ps
`include "fcs_consts.svh"

module fcs_fifo #(
  parameter int W = `FCS_BYTE_W,
  parameter int D = `FCS_FIFO_DEPTH
) (
  input wire logic clk,          // System clock
  input wire logic reset_n,      // Async reset, active low
  input wire logic inValid,      // Write request
  output logic inReady,          // Room for a word
  input wire logic [W-1:0] inData, // Write word
  output logic outValid,         // Word available
  input wire logic outReady,     // Reader takes word
  output logic [W-1:0] outData   // Head word
);
  localparam int AW = $clog2(D);
  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("fcs_fifo depth must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fcs_fifo_s;
  fcs_fifo_s q, d;
  logic doWr, doRd;
  assign inReady = (q.cnt != (AW+1)'(D));
  assign outValid = (q.cnt != '0);
  assign outData = q.mem[q.rd];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  always_comb begin
    d = q;
    if (doWr) begin
      d.mem[q.wr] = inData;
      d.wr = q.wr + 1'b1;
    end
    if (doRd) begin
      d.rd = q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(doWr) - (AW+1)'(doRd);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

module fcs_top #(
  parameter int POR_CYC = `FCS_POR_CYC,
  parameter int STATUS_MIN_CYC = `FCS_STATUS_MIN_CYC,
  parameter int CD2UM_CYC = `FCS_CD2UM_CYC,
  parameter int INIT_CYCLES = `FCS_INIT_CYCLES,
  parameter int FIFO_DEPTH = `FCS_FIFO_DEPTH
) (
  input wire logic clk,             // 200 MHz system clock
  input wire logic reset_n,         // Async reset, active low
  input wire logic cfgRequestN,     // Request pin, low starts config
  input wire logic cfgByteClock,    // Byte clock pin
  input wire logic [7:0] cfgData,   // Byte data pins
  input wire logic userInitClock,   // User init clock pin
  input wire logic [3:0] schemeSelectPins, // Scheme straps
  input wire logic useUserInitClk,  // Start-up from user clock
  input wire logic coreLoadDone,    // Core has all data
  input wire logic tck,             // Test clock pin
  input wire logic tms,             // Test mode select pin
  input wire logic tdi,             // Test data in pin
  output logic tdo,                 // Test data out
  output logic tdoOeN,              // TDO enable, low drives
  output logic loadCompleteO,       // Load-complete pin value
  output logic loadCompleteOeN,     // Low pulls line low
  output logic healthO,             // Health pin value
  output logic healthOeN,           // Low pulls line low
  output logic byteClkO,            // Byte clock out, active serial
  output logic byteClkOeN,          // Byte clock enable, low drives
  output logic userIoHiZ,           // Tri-state all user pins
  output logic userMode,            // Device is in user mode
  output logic jtagCfgActive,       // Scan load in progress
  output logic byteOverflow,        // Byte lost to a full FIFO
  output logic byteValid,           // Byte to core valid
  input wire logic byteReady,       // Core takes byte
  output logic [7:0] byteData,      // Byte to core
  output logic fifoReady            // FIFO has room
);
  localparam int CW = `FCS_CNT_W;
  if (POR_CYC >= (1 << CW) || STATUS_MIN_CYC >= (1 << CW) ||
      CD2UM_CYC >= (1 << CW) || INIT_CYCLES >= (1 << CW) ||
      POR_CYC < 1 || STATUS_MIN_CYC < 1 || CD2UM_CYC < 1) begin : g_chk
    $error("fcs_top count parameter out of range");
  end
  typedef struct packed {
    fcs_pkg::fcs_pins_s pin1;  // First synchroniser stage
    fcs_pkg::fcs_pins_s pin2;  // Second stage, safe to read
    fcs_pkg::fcs_pins_s pin3;  // Delayed copy for edges
    fcs_pkg::fcs_state_e st;
    logic [CW-1:0] cnt;
    logic [CW-1:0] hLow;       // Length of the current health-low span
    logic [1:0] falls;
    logic [3:0] scheme;
    fcs_pkg::fcs_tap_e tap;
    logic [`FCS_IR_W-1:0] irSh;
    logic [`FCS_IR_W-1:0] ir;
    logic [7:0] dsr;
    logic [2:0] bitCnt;
    logic byp;
    logic jtag;
    logic tdoR;
    logic tdoOn;
    logic pushV;
    logic [7:0] pushD;
    logic ovf;
    logic div;
  } fcs_top_s;
  fcs_top_s q, d;
  logic reqN, dclkRise, dclkFall, uclkRise, tckRise, tckFall, prog;
  logic fifoIn;

  function automatic fcs_pkg::fcs_tap_e tapStep(fcs_pkg::fcs_tap_e s,
                                                logic m);
    case (s)
      fcs_pkg::TAP_TLR: tapStep = m ? fcs_pkg::TAP_TLR : fcs_pkg::TAP_RTI;
      fcs_pkg::TAP_RTI: tapStep = m ? fcs_pkg::TAP_SELDR : fcs_pkg::TAP_RTI;
      fcs_pkg::TAP_SELDR: tapStep = m ? fcs_pkg::TAP_SELIR :
                                        fcs_pkg::TAP_CAPDR;
      fcs_pkg::TAP_CAPDR: tapStep = m ? fcs_pkg::TAP_EX1DR : fcs_pkg::TAP_SHDR;
      fcs_pkg::TAP_SHDR: tapStep = m ? fcs_pkg::TAP_EX1DR : fcs_pkg::TAP_SHDR;
      fcs_pkg::TAP_EX1DR: tapStep = m ? fcs_pkg::TAP_UPDR : fcs_pkg::TAP_PSDR;
      fcs_pkg::TAP_PSDR: tapStep = m ? fcs_pkg::TAP_EX2DR : fcs_pkg::TAP_PSDR;
      fcs_pkg::TAP_EX2DR: tapStep = m ? fcs_pkg::TAP_UPDR : fcs_pkg::TAP_SHDR;
      fcs_pkg::TAP_UPDR: tapStep = m ? fcs_pkg::TAP_SELDR : fcs_pkg::TAP_RTI;
      fcs_pkg::TAP_SELIR: tapStep = m ? fcs_pkg::TAP_TLR : fcs_pkg::TAP_CAPIR;
      fcs_pkg::TAP_CAPIR: tapStep = m ? fcs_pkg::TAP_EX1IR : fcs_pkg::TAP_SHIR;
      fcs_pkg::TAP_SHIR: tapStep = m ? fcs_pkg::TAP_EX1IR : fcs_pkg::TAP_SHIR;
      fcs_pkg::TAP_EX1IR: tapStep = m ? fcs_pkg::TAP_UPIR : fcs_pkg::TAP_PSIR;
      fcs_pkg::TAP_PSIR: tapStep = m ? fcs_pkg::TAP_EX2IR : fcs_pkg::TAP_PSIR;
      fcs_pkg::TAP_EX2IR: tapStep = m ? fcs_pkg::TAP_UPIR : fcs_pkg::TAP_SHIR;
      fcs_pkg::TAP_UPIR: tapStep = m ? fcs_pkg::TAP_SELDR : fcs_pkg::TAP_RTI;
      default: tapStep = fcs_pkg::TAP_TLR;
    endcase
  endfunction

  // Edges come from the second and third stages only
  assign reqN = q.pin2.req;
  assign dclkRise = q.pin2.cfg_byte_clock && !q.pin3.cfg_byte_clock;
  assign dclkFall = !q.pin2.cfg_byte_clock && q.pin3.cfg_byte_clock;
  assign uclkRise = q.pin2.uclk && !q.pin3.uclk;
  assign tckRise = q.pin2.tck && !q.pin3.tck;
  assign tckFall = !q.pin2.tck && q.pin3.tck;
  assign prog = (q.ir == `FCS_IR_PROGRAM);

  always_comb begin
    d = q;
    d.pin1 = '{req: cfgRequestN, cfg_byte_clock: cfgByteClock, data: cfgData,
               uclk: userInitClock, tck: tck, tms: tms, tdi: tdi,
               sel: schemeSelectPins};
    d.pin2 = q.pin1;
    d.pin3 = q.pin2;
    d.pushV = 1'b0;
    d.div = !q.div;
    d.cnt = (q.cnt == '1) ? q.cnt : q.cnt + 1'b1;
    // Kept apart from the sequence counter so the width check is independent
    d.hLow = (q.hLow == '1) ? q.hLow : q.hLow + 1'b1;
    if (healthOeN) begin
      d.hLow = '0;
    end
    // Boundary-scan side
    if (tckRise) begin
      d.tap = tapStep(q.tap, q.pin2.tms);
      case (q.tap)
        fcs_pkg::TAP_CAPIR: d.irSh = `FCS_IR_CAPTURE;
        fcs_pkg::TAP_SHIR: d.irSh = {q.pin2.tdi, q.irSh[`FCS_IR_W-1:1]};
        fcs_pkg::TAP_UPIR: begin
          d.ir = q.irSh;
          d.jtag = (q.irSh == `FCS_IR_PROGRAM);
        end
        fcs_pkg::TAP_CAPDR: begin
          d.byp = 1'b0;
          d.bitCnt = '0;
        end
        fcs_pkg::TAP_SHDR: begin
          d.byp = q.pin2.tdi;
          if (prog) begin
            d.dsr = {q.pin2.tdi, q.dsr[7:1]};
            d.bitCnt = q.bitCnt + 1'b1;
            if (q.bitCnt == 3'h7) begin
              d.pushV = 1'b1;
              d.pushD = {q.pin2.tdi, q.dsr[7:1]};
            end
          end
        end
        fcs_pkg::TAP_TLR: begin
          d.ir = `FCS_IR_BYPASS;
          d.jtag = 1'b0;
        end
        default: ;
      endcase
    end
    // TDO moves only on the falling edge so the far end samples it stable
    if (tckFall) begin
      d.tdoOn = (q.tap == fcs_pkg::TAP_SHIR) || (q.tap == fcs_pkg::TAP_SHDR);
      d.tdoR = (q.tap == fcs_pkg::TAP_SHIR) ? q.irSh[0] :
               (prog ? q.dsr[0] : q.byp);
    end
    // Configuration sequence
    case (q.st)
      fcs_pkg::ST_POR: begin
        if (q.cnt >= CW'(POR_CYC - 1)) begin
          d.scheme = q.pin2.sel;
          d.st = fcs_pkg::ST_RESET;
          d.cnt = '0;
        end
      end
      fcs_pkg::ST_RESET: begin
        if (!reqN) begin
          d.cnt = '0;
        end else if (q.cnt >= CW'(STATUS_MIN_CYC - 1)) begin
          d.st = fcs_pkg::ST_LOAD;
        end
      end
      fcs_pkg::ST_LOAD: begin
        if (dclkRise) begin
          d.pushV = 1'b1;
          d.pushD = q.pin2.data;
        end
        if (coreLoadDone) begin
          d.st = fcs_pkg::ST_INITW;
          d.cnt = '0;
          d.falls = '0;
        end
      end
      fcs_pkg::ST_INITW: begin
        // Two trailing byte-clock falls must be seen before start-up
        if (dclkFall) begin
          d.falls = q.falls + 1'b1;
        end
        if (q.falls == `FCS_DONE_FALLS) begin
          d.st = fcs_pkg::ST_INITD;
        end
      end
      fcs_pkg::ST_INITD: begin
        if (useUserInitClk) begin
          if (q.cnt >= CW'(`FCS_CD2CU_CYC - 1)) begin
            d.st = fcs_pkg::ST_INITU;
            d.cnt = '0;
          end
        end else if (q.cnt >= CW'(CD2UM_CYC - 1)) begin
          d.st = fcs_pkg::ST_USER;
        end
      end
      fcs_pkg::ST_INITU: begin
        d.cnt = q.cnt + CW'(uclkRise);
        if (q.cnt >= CW'(INIT_CYCLES)) begin
          d.st = fcs_pkg::ST_USER;
        end
      end
      fcs_pkg::ST_USER: ;
      fcs_pkg::ST_JTAG: begin
        if (coreLoadDone) begin
          d.st = fcs_pkg::ST_INITD;
          d.cnt = '0;
        end else if (!q.jtag) begin
          d.st = fcs_pkg::ST_RESET;
          d.cnt = '0;
        end
      end
      default: d.st = fcs_pkg::ST_RESET;
    endcase
    if (q.st != fcs_pkg::ST_POR) begin
      if (q.jtag && q.st != fcs_pkg::ST_JTAG &&
          q.st != fcs_pkg::ST_INITD && q.st != fcs_pkg::ST_INITU &&
          q.st != fcs_pkg::ST_USER) begin
        d.st = fcs_pkg::ST_JTAG;
      end
      if (!reqN && !q.jtag && q.st != fcs_pkg::ST_RESET) begin
        d.st = fcs_pkg::ST_RESET;
        d.cnt = '0;
      end
    end
    if (q.st == fcs_pkg::ST_RESET) begin
      d.ovf = 1'b0;
    end
    // A byte offered to a full FIFO is dropped and remembered; set wins
    if (q.pushV && !fifoReady) begin
      d.ovf = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= fcs_pkg::ST_POR;
      q.tap <= fcs_pkg::TAP_TLR;
      q.ir <= `FCS_IR_BYPASS;
      q.pin1.req <= 1'b1;
      q.pin2.req <= 1'b1;
      q.pin3.req <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign fifoIn = q.pushV;
  fcs_fifo #(.W(`FCS_BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(fifoIn),
    .inReady(fifoReady),
    .inData(q.pushD),
    .outValid(byteValid),
    .outReady(byteReady),
    .outData(byteData)
  );

  // Health line low during power-on delay and reset; done low until loaded
  assign healthO = 1'b0;
  assign healthOeN = !(q.st == fcs_pkg::ST_POR ||
                       q.st == fcs_pkg::ST_RESET);
  assign loadCompleteO = 1'b0;
  assign loadCompleteOeN = !(q.st == fcs_pkg::ST_POR ||
                             q.st == fcs_pkg::ST_RESET ||
                             q.st == fcs_pkg::ST_LOAD ||
                             q.st == fcs_pkg::ST_JTAG);
  assign tdo = q.tdoR;
  assign tdoOeN = !q.tdoOn;
  assign byteClkO = q.div;
  assign byteClkOeN = !(q.scheme == `FCS_SEL_ACTIVE_SERIAL &&
                        q.st == fcs_pkg::ST_LOAD && !q.jtag);
  assign userIoHiZ = q.jtag || q.st != fcs_pkg::ST_USER;
  assign userMode = q.st == fcs_pkg::ST_USER;
  assign jtagCfgActive = q.jtag;
  assign byteOverflow = q.ovf;

  AST_DONE_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    (!reqN && !q.jtag && q.st != fcs_pkg::ST_POR) |=> !loadCompleteOeN)
    else $error("load-complete not pulled low after request");
  AST_HEALTH_LOW: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(q.pin2.req) && !q.jtag |-> ##[0:1] !healthOeN)
    else $error("health line not pulled low after request");
  AST_HEALTH_MIN: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(healthOeN) |-> q.hLow >= CW'(STATUS_MIN_CYC))
    else $error("health line released too early");
  AST_HEALTH_REL: assert property (@(posedge clk) disable iff (!reset_n)
    (q.st == fcs_pkg::ST_RESET && reqN && !q.jtag &&
     q.cnt >= CW'(STATUS_MIN_CYC - 1)) |=> healthOeN)
    else $error("health line not released");
  AST_OSC_USER: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(userMode) && $past(q.st) == fcs_pkg::ST_INITD |->
      $past(q.cnt) >= CW'(CD2UM_CYC - 1))
    else $error("user mode entered before start-up delay");
  AST_UCLK_EN: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(q.st) && q.st == fcs_pkg::ST_INITU |->
      $past(q.cnt) >= CW'(`FCS_CD2CU_CYC - 1))
    else $error("user clock enabled too early");
  AST_UCLK_USER: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(userMode) && $past(q.st) == fcs_pkg::ST_INITU |->
      $past(q.cnt) >= CW'(INIT_CYCLES))
    else $error("user mode before init clock cycles");
  AST_POR_HEALTH: assert property (@(posedge clk) disable iff (!reset_n)
    q.st == fcs_pkg::ST_POR |-> !healthOeN && !loadCompleteOeN)
    else $error("health line released during power-on delay");
  AST_RECONFIG: assert property (@(posedge clk) disable iff (!reset_n)
    (userMode && !reqN && !q.jtag) |=> q.st == fcs_pkg::ST_RESET ##1
      !loadCompleteOeN)
    else $error("request low in user mode ignored");
  AST_SCAN_WINS: assert property (@(posedge clk) disable iff (!reset_n)
    (q.jtag && q.st == fcs_pkg::ST_LOAD) |=> q.st == fcs_pkg::ST_JTAG)
    else $error("passive load not aborted by scan load");
  AST_NO_CFG_BYTE_CLOCK: assert property (@(posedge clk) disable iff (!reset_n)
    q.jtag |-> byteClkOeN)
    else $error("byte clock driven during scan load");
  AST_HIZ: assert property (@(posedge clk) disable iff (!reset_n)
    q.jtag |-> userIoHiZ)
    else $error("user pins active during scan load");
  AST_TDI_RISE: assert property (@(posedge clk) disable iff (!reset_n)
    (tckRise && q.tap == fcs_pkg::TAP_SHDR && prog) |=>
      q.dsr[7] == $past(q.pin2.tdi))
    else $error("TDI not sampled on rising TCK");
  AST_TDO_FALL: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(q.tdoR) || $changed(q.tdoOn) |-> $past(tckFall))
    else $error("TDO changed off the falling TCK");
  AST_TAP_RISE: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(q.tap) |-> $past(tckRise))
    else $error("TAP moved off the rising TCK");
  AST_BYTE_CAP: assert property (@(posedge clk) disable iff (!reset_n)
    (dclkRise && q.st == fcs_pkg::ST_LOAD && reqN) |=>
      q.pushV && q.pushD == $past(q.pin2.data))
    else $error("byte not captured on byte clock");
endmodule

// [fcs_host_model.sv]
// Host controller model driving the load pins and the test port
`timescale 1ns/1ps

module fcs_host_model #(
  parameter int HALF_BCLK = 16,
  parameter int HALF_TCK = 8,
  parameter int START_GAP = 40
) (
  input wire logic clk,     // System clock of the bench
  input wire logic tdo,     // Test data from the device
  input wire logic tdoOeN,  // Low while the device drives tdo
  output logic reqN,        // Configuration request, active low
  output logic byteClk,     // Byte clock, still outside frames
  output logic [7:0] data,  // Byte data
  output logic tck,         // Test clock, still outside frames
  output logic tms,         // Test mode select
  output logic tdi          // Test data in
);
  initial begin
    reqN = 1'b1;
    byteClk = 1'b0;
    data = 8'h00;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end

  task automatic request_pulse(input int lowCyc);
    @(posedge clk);
    reqN <= 1'b0;
    repeat (lowCyc) @(posedge clk);
    reqN <= 1'b1;
  endtask

  // Called once the health line is high; no edges before that
  task automatic gap();
    repeat (START_GAP) @(posedge clk);
  endtask

  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    data <= b;
    repeat (HALF_BCLK) @(posedge clk);
    byteClk <= 1'b1;
    repeat (HALF_BCLK) @(posedge clk);
    byteClk <= 1'b0;
    repeat (HALF_BCLK) @(posedge clk);
    // Bus inverted: never leave the last byte standing
    data <= ~b;
  endtask

  task automatic two_falls();
    repeat (2) send_byte(8'h00);
  endtask

  task automatic tap_step(input logic m, input logic d, output logic seen);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (HALF_TCK) @(posedge clk);
    // An undriven line must not look like valid data
    seen = tdoOeN ? !tdo : tdo;
    tck <= 1'b1;
    repeat (HALF_TCK - 1) @(posedge clk);
  endtask

  task automatic tap_shift(input logic [7:0] v, input int n,
                           output logic [7:0] seen);
    logic b;
    seen = 8'h00;
    for (int i = 0; i < n; i++) begin
      tap_step(i == n - 1, v[i], b);
      seen[i] = b;
    end
  endtask

  task automatic tap_moves(input logic [7:0] path, input int n);
    logic b;
    for (int i = 0; i < n; i++) begin
      tap_step(path[i], 1'b1, b);
    end
    @(posedge clk);
    tck <= 1'b0;
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench of the configuration sequencer
`timescale 1ns/1ps

module tb_top;
  localparam int POR = 20;
  localparam int STAT = 30;
  // Longer than the two trailing frames, so an early start shows
  localparam int CD2UM = 200;
  localparam int INIT = 4;
  logic clk, reset_n, reqN, bClk, uClk, useUClk, done, tck, tms, tdi;
  logic tdo, tdoOeN, lcO, lcOeN, hO, healthOeN, bcO, byteClkOeN;
  logic userIoHiZ, userMode, jtagCfgActive, byteOverflow;
  logic byteValid, byteReady, fifoReady;
  logic [7:0] data, byteData;
  logic [3:0] selPins;
  int n_fail = 0;
  int comparisons = 0;

  fcs_top #(.POR_CYC(POR), .STATUS_MIN_CYC(STAT), .CD2UM_CYC(CD2UM),
    .INIT_CYCLES(INIT), .FIFO_DEPTH(8)) fcs_top_i (.clk(clk),
    .reset_n(reset_n), .cfgRequestN(reqN), .cfgByteClock(bClk),
    .cfgData(data), .userInitClock(uClk), .schemeSelectPins(selPins),
    .useUserInitClk(useUClk), .coreLoadDone(done), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .loadCompleteO(lcO),
    .loadCompleteOeN(lcOeN), .healthO(hO), .healthOeN(healthOeN),
    .byteClkO(bcO), .byteClkOeN(byteClkOeN), .userIoHiZ(userIoHiZ),
    .userMode(userMode), .jtagCfgActive(jtagCfgActive),
    .byteOverflow(byteOverflow), .byteValid(byteValid),
    .byteReady(byteReady), .byteData(byteData), .fifoReady(fifoReady));

  fcs_host_model fcs_host_model_i (.clk(clk), .tdo(tdo), .tdoOeN(tdoOeN),
    .reqN(reqN),
    .byteClk(bClk), .data(data), .tck(tck), .tms(tms), .tdi(tdi));

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return healthOeN;
      1: return lcOeN;
      default: return userMode;
    endcase
  endfunction

  // Bounded wait; a hang ends the run through the report
  task automatic wait_for(input int w, input logic v, input int lim,
                          output int cyc);
    cyc = 0;
    while (pick(w) !== v && cyc < lim) begin
      @(posedge clk);
      cyc++;
    end
    if (cyc >= lim) begin
      n_fail++;
      $display("mismatch wait %0d expected %b seen timeout", w, v);
      final_report();
    end
  endtask

  task automatic t_power_on();
    int c;
    repeat (POR / 2) @(posedge clk);
    chk("health in por", 8'h00, 8'(healthOeN));
    chk("done in por", 8'h00, 8'(lcOeN));
    chk("user pins hiz", 8'h01, 8'(userIoHiZ));
    wait_for(0, 1'b1, POR + STAT + 50, c);
    chk("health span", 8'h01, 8'(c + POR / 2 >= POR + STAT));
    $display("test power_on done");
  endtask

  task automatic t_fill();
    fcs_host_model_i.gap();
    for (int i = 0; i < 9; i++) begin
      fcs_host_model_i.send_byte(8'h30 + 8'(i));
      if (i == 0) chk("serial clock", 8'h00, 8'(byteClkOeN));
      if (i == 7) chk("fifo full", 8'h00, 8'(fifoReady));
    end
    chk("overflow", 8'h01, 8'(byteOverflow));
    for (int i = 0; i < 8; i++) begin
      chk("fifo valid", 8'h01, 8'(byteValid));
      chk("fifo byte", 8'h30 + 8'(i), byteData);
      byteReady <= 1'b1;
      @(posedge clk);
      byteReady <= 1'b0;
      repeat (2) @(posedge clk);
    end
    chk("fifo empty", 8'h00, 8'(byteValid));
    $display("test fill done");
  endtask

  task automatic t_start_osc();
    int c1;
    int c2;
    chk("done during load", 8'h00, 8'(lcOeN));
    done <= 1'b1;
    wait_for(1, 1'b1, 10, c1);
    fcs_host_model_i.two_falls();
    wait_for(2, 1'b1, CD2UM + 130, c2);
    // From done seen high: two byte-clock frames, then start-up
    chk("start-up min", 8'h01, 8'(98 + c2 >= CD2UM));
    chk("user pins on", 8'h00, 8'(userIoHiZ));
    done <= 1'b0;
    $display("test start_osc done");
  endtask

  task automatic t_reconfig();
    int c;
    int d;
    chk("user mode before", 8'h01, 8'(userMode));
    fork
      fcs_host_model_i.request_pulse(100);
      begin
        wait_for(0, 1'b0, 110, c);
        chk("health fall time", 8'h01, 8'(c <= 100));
        chk("done low", 8'h00, 8'(lcOeN));
        chk("user mode left", 8'h00, 8'(userMode));
        wait_for(0, 1'b1, 300, d);
        chk("health low min", 8'h01, 8'(d >= STAT));
        chk("health release", 8'h01, 8'(d <= 100 + 160));
      end
    join
    fcs_host_model_i.gap();
    $display("test reconfig done");
  endtask

  task automatic t_start_user();
    int c;
    useUClk <= 1'b1;
    done <= 1'b1;
    wait_for(1, 1'b1, 10, c);
    fcs_host_model_i.two_falls();
    repeat (20) @(posedge clk);
    for (int i = 0; i < INIT; i++) begin
      if (i == INIT - 1) chk("early user", 8'h00, 8'(userMode));
      uClk <= 1'b1;
      repeat (4) @(posedge clk);
      uClk <= 1'b0;
      repeat (4) @(posedge clk);
    end
    wait_for(2, 1'b1, 20, c);
    done <= 1'b0;
    useUClk <= 1'b0;
    $display("test start_user done");
  endtask

  task automatic t_jtag();
    logic [7:0] s;
    logic b;
    int c;
    chk("serial clock load", 8'h00, 8'(byteClkOeN));
    b = bcO;
    @(posedge clk);
    chk("serial clock toggle", 8'(!b), 8'(bcO));
    fcs_host_model_i.tap_moves(8'h1f, 6);
    fcs_host_model_i.tap_moves(8'h03, 4);
    fcs_host_model_i.tap_shift(8'h02, 4, s);
    chk("ir capture", 8'h01, s);
    chk("tdo driven", 8'h00, 8'(tdoOeN));
    fcs_host_model_i.tap_moves(8'h01, 2);
    chk("tdo released", 8'h01, 8'(tdoOeN));
    chk("scan active", 8'h01, 8'(jtagCfgActive));
    chk("scan hiz", 8'h01, 8'(userIoHiZ));
    chk("scan no clock", 8'h01, 8'(byteClkOeN));
    fcs_host_model_i.tap_moves(8'h01, 3);
    fcs_host_model_i.tap_shift(8'h5a, 8, s);
    fcs_host_model_i.tap_moves(8'h01, 2);
    chk("scan byte valid", 8'h01, 8'(byteValid));
    chk("scan byte", 8'h5a, byteData);
    done <= 1'b1;
    wait_for(2, 1'b1, CD2UM + 20, c);
    chk("scan start-up", 8'h01, 8'(c >= CD2UM));
    chk("scan user hiz", 8'h01, 8'(userIoHiZ));
    fcs_host_model_i.tap_moves(8'h1f, 5);
    chk("scan ended", 8'h00, 8'(jtagCfgActive));
    chk("user pins after scan", 8'h00, 8'(userIoHiZ));
    done <= 1'b0;
    $display("test jtag done");
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset_n = 1'b0;
    uClk = 1'b0;
    useUClk = 1'b0;
    done = 1'b0;
    byteReady = 1'b0;
    selPins = 4'h2;
    repeat (8) @(posedge clk);
    chk("reset health", 8'h00, 8'(healthOeN));
    chk("reset tdo enable", 8'h01, 8'(tdoOeN));
    chk("reset fifo room", 8'h01, 8'(fifoReady));
    chk("done pin level", 8'h00, 8'(lcO));
    chk("health pin level", 8'h00, 8'(hO));
    reset_n <= 1'b1;
    t_power_on();
    t_fill();
    t_start_osc();
    t_reconfig();
    t_start_user();
    t_reconfig();
    t_jtag();
    final_report();
  end
endmodule
